// File: barof_pkg.sv
// constants, carriers and state codes shared by the converter control block
package barof_pkg;

    // =========================================================
    // clocking and timing
    localparam int unsigned PCLK_HZ       = 250_000_000;
    localparam int unsigned DETECT_HZ     = 200_000;
    localparam int unsigned DETECT_CYCLES = PCLK_HZ / DETECT_HZ;
    localparam int unsigned OSC_HZ        = 4_915_200;
    localparam int unsigned OSC_DIV       = PCLK_HZ / OSC_HZ;
    localparam int unsigned MOD_DIV       = 64;
    localparam int unsigned DEC_SLOW      = 7680;
    localparam int unsigned DEC_FAST      = 960;
    localparam int unsigned SHIFT_SLOW    = 32;
    localparam int unsigned SHIFT_FAST    = 20;
    localparam int unsigned SETTLE_CONV   = 4;

    // =========================================================
    // result format
    localparam int unsigned RES_W      = 20;
    localparam int unsigned PAD_BITS   = 4;
    localparam int unsigned FRAME_BITS = RES_W + PAD_BITS;
    localparam logic [19:0] CODE_POS_FS = 20'h7FFFF;
    localparam logic [19:0] CODE_NEG_FS = 20'h80000;
    localparam logic [3:0]  PAD_ONES    = 4'hF;

    // =========================================================
    // register map
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_RESULT  = 8'h08;
    localparam int unsigned CTRL_RESTART_BIT = 0;
    localparam int unsigned CTRL_FORCE_BIT   = 1;
    localparam logic        CTRL_FORCE_RESET = 1'b0;

    // =========================================================
    // carriers
    typedef struct packed {
        logic        valid;
        logic [19:0] code;
    } barof_sample_t;

    typedef struct packed {
        logic powered;
        logic ready;
        logic settled;
        logic fast;
        logic int_clk;
    } barof_status_t;

    typedef enum logic [2:0] {
        SO_IDLE  = 3'b001,
        SO_READY = 3'b010,
        SO_SHIFT = 3'b100
    } barof_so_state_t;

endpackage : barof_pkg

// File: barof_clk_select.sv
// converter clock source selection and modulator sample tick
`timescale 1ns/1ps
module barof_clk_select
    import barof_pkg::*;
#(
    parameter int unsigned DET_CYC = DETECT_CYCLES
)(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic ext_clk_s,
    input  wire logic force_int,
    output logic      int_clk,
    output logic      conv_tick,
    output logic      mod_tick
);
    localparam int unsigned GW = $clog2(DET_CYC + 1);
    localparam logic [GW-1:0] GAP_MAX = GW'(DET_CYC - 1);
    localparam logic [5:0]    OSC_MAX = 6'(OSC_DIV - 1);
    localparam logic [5:0]    MOD_MAX = 6'(MOD_DIV - 1);

    logic          ext_d_r, ext_d_nxt;
    logic [GW-1:0] gap_r, gap_nxt;
    logic          det_r, det_nxt;
    logic [5:0]    osc_r, osc_nxt;
    logic [5:0]    mod_r, mod_nxt;
    logic          ext_rise;
    logic          osc_tick;

    // =========================================================
    // detection and dividers
    always_comb begin
        ext_rise  = ext_clk_s & ~ext_d_r;
        ext_d_nxt = ext_clk_s;
        gap_nxt   = ext_rise ? '0 : (gap_r == GAP_MAX ? gap_r : gap_r + 1'b1);
        det_nxt   = det_r;
        if (gap_r == GAP_MAX) begin
            det_nxt = 1'b1;
        end else if (ext_rise) begin
            det_nxt = 1'b0;
        end
        int_clk   = det_r | force_int;
        osc_tick  = (osc_r == OSC_MAX);
        osc_nxt   = osc_tick ? '0 : osc_r + 1'b1;
        conv_tick = int_clk ? osc_tick : ext_rise;
        mod_tick  = conv_tick && (mod_r == MOD_MAX);
        mod_nxt   = conv_tick ? mod_r + 1'b1 : mod_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_d_r <= 1'b0;
            gap_r   <= '0;
            det_r   <= 1'b1;
            osc_r   <= '0;
            mod_r   <= '0;
        end else if (ce) begin
            ext_d_r <= ext_d_nxt;
            gap_r   <= gap_nxt;
            det_r   <= det_nxt;
            osc_r   <= osc_nxt;
            mod_r   <= mod_nxt;
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_int_on_gap: assert property (ce && gap_r == GAP_MAX |=> det_r)
        else $error("slow external clock did not select oscillator");
    chk_ext_on_edge: assert property (
        ce && ext_rise && gap_r != GAP_MAX |=> !det_r)
        else $error("fast external clock not selected");
    chk_mod_divide: assert property (
        ce && mod_tick |=> mod_r == 6'h00 && !mod_tick)
        else $error("modulator tick not a fixed division");

endmodule : barof_clk_select

// File: barof_sinc4.sv
// fourth order sinc decimator with saturating 20-bit output
`timescale 1ns/1ps
module barof_sinc4
    import barof_pkg::*;
#(
    parameter int unsigned W          = 56,
    parameter int unsigned DEC_SLOW_P = DEC_SLOW,
    parameter int unsigned DEC_FAST_P = DEC_FAST
)(
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    ce,
    input  wire logic    clr,
    input  wire logic    mod_tick,
    input  wire logic    mod_bit,
    input  wire logic    fast,
    output barof_sample_t sample
);
    localparam int unsigned DW = $clog2(DEC_SLOW_P + 1);

    logic signed [W-1:0] integ_r [4];
    logic signed [W-1:0] integ_nxt [4];
    logic signed [W-1:0] dly_r [4];
    logic signed [W-1:0] dly_nxt [4];
    logic signed [W-1:0] stage [5];
    logic signed [W-1:0] x;
    logic signed [W-1:0] scaled;
    logic [DW-1:0]       dec_r, dec_nxt, dec_max;
    barof_sample_t       sample_r, sample_nxt;
    logic                last;
    logic                over_pos;
    logic                over_neg;

    // =========================================================
    // integrators, combs and output format
    always_comb begin
        x        = mod_bit ? W'(1) : {W{1'b1}};
        dec_max  = fast ? DW'(DEC_FAST_P - 1) : DW'(DEC_SLOW_P - 1);
        last     = (dec_r == dec_max);
        integ_nxt = integ_r;
        dly_nxt   = dly_r;
        dec_nxt   = dec_r;
        sample_nxt = '{valid: 1'b0, code: sample_r.code};
        stage[0] = integ_r[3];
        for (int k = 0; k < 4; k++) begin
            stage[k+1] = stage[k] - dly_r[k];
        end
        scaled   = stage[4] >>> (fast ? SHIFT_FAST : SHIFT_SLOW);
        over_pos = !scaled[W-1] && (|scaled[W-2:RES_W-1]);
        over_neg = scaled[W-1] && !(&scaled[W-2:RES_W-1]);
        if (mod_tick) begin
            integ_nxt[0] = integ_r[0] + x;
            for (int k = 1; k < 4; k++) begin
                integ_nxt[k] = integ_r[k] + integ_nxt[k-1];
            end
            dec_nxt = last ? '0 : dec_r + 1'b1;
            if (last) begin
                for (int k = 0; k < 4; k++) begin
                    dly_nxt[k] = stage[k];
                end
                sample_nxt.valid = 1'b1;
                if (over_pos) begin
                    sample_nxt.code = CODE_POS_FS;
                end else if (over_neg) begin
                    sample_nxt.code = CODE_NEG_FS;
                end else begin
                    sample_nxt.code = scaled[RES_W-1:0];
                end
            end
        end
        if (clr) begin
            for (int k = 0; k < 4; k++) begin
                integ_nxt[k] = '0;
                dly_nxt[k]   = '0;
            end
            dec_nxt          = '0;
            sample_nxt.valid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 4; k++) begin
                integ_r[k] <= '0;
                dly_r[k]   <= '0;
            end
            dec_r    <= '0;
            sample_r <= '0;
        end else if (ce) begin
            integ_r  <= integ_nxt;
            dly_r    <= dly_nxt;
            dec_r    <= dec_nxt;
            sample_r <= sample_nxt;
        end else begin
            sample_r.valid <= 1'b0;
        end
    end

    assign sample = sample_r;

    // =========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_sat_positive: assert property (
        ce && !clr && mod_tick && last && over_pos
        |=> sample.valid && sample.code == CODE_POS_FS)
        else $error("positive overrange did not clip");
    chk_sat_negative: assert property (
        ce && !clr && mod_tick && last && over_neg
        |=> sample.valid && sample.code == CODE_NEG_FS)
        else $error("negative overrange did not clip");
    chk_decim_rate: assert property (
        sample.valid |-> $past(ce && mod_tick && last && !clr))
        else $error("result not at end of decimation period");

endmodule : barof_sinc4

// File: barof_top.sv
// converter digital side: clocking, decimation, serial result, apb registers
// =============================================================
// Overview of operation
// - fast external clock: detector output low, external clock used, oscillator divider still counting
// - external clock slow or absent: detector output high, internal oscillator used
// - rate select low gives nominal 10 per second, high gives 80
// - external clock divided by 491520 slow or 61440 fast per result
// - modulator samples at converter clock divided by 64
// - third order modulator bitstream feeds a sinc4 decimator
// - slow rate puts filter notches at every 10 Hz multiple
// - result is a 20-bit two's complement word
// - overrange clips to 7FFFF or 80000, never wraps
// - host clocks the 20 result bits out, most significant first
// - clocks 21 to 24 give ones on the data line
// - result counts as settled from the fifth complete conversion after a clear
// - power-off input low clears filter, settling count and serial output; result register holds, dividers run
// - line low signals new data; each rising serial clock edge after a result is loaded shifts a bit, none while idle
// - line going low marks a new result available
`timescale 1ns/1ps
module barof_top
    import barof_pkg::*;
#(
    parameter int unsigned DEC_SLOW_P = DEC_SLOW,
    parameter int unsigned DEC_FAST_P = DEC_FAST,
    parameter int unsigned DET_CYC    = DETECT_CYCLES
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_clock_input,
    input  wire logic        rate_select,
    input  wire logic        power_off_n,
    input  wire logic        serial_clock,
    input  wire logic        modulator_bit,
    output logic             ready_and_serial_out
);
    localparam int unsigned NSYNC = 5;
    localparam logic [4:0] FRAME_CNT = 5'(FRAME_BITS);
    localparam logic [4:0] DATA_CNT  = 5'(RES_W);
    localparam logic [2:0] SETTLE_N  = 3'(SETTLE_CONV);

    // =========================================================
    // pin synchronisers
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] pins;

    assign pins = {modulator_bit, serial_clock, power_off_n,
                   rate_select, external_clock_input};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1_r[i] <= 1'b0;
                sync2_r[i] <= 1'b0;
            end else if (ce) begin
                sync1_r[i] <= pins[i];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end

    logic ext_s, fast_s, pdn_s, sclk_s, mbit_s;
    assign ext_s  = sync2_r[0];
    assign fast_s = sync2_r[1];
    assign pdn_s  = sync2_r[2];
    assign sclk_s = sync2_r[3];
    assign mbit_s = sync2_r[4];

    // =========================================================
    // apb registers
    logic        force_int_r, force_int_nxt;
    logic        restart_req;
    logic [31:0] prdata_r, prdata_nxt;
    logic        wr_en;
    logic        addr_ok;
    logic [19:0] result_r, result_nxt;
    logic        settled_r, settled_nxt;
    logic [2:0]  settle_cnt_r, settle_cnt_nxt;
    barof_so_state_t so_st_r, so_st_nxt;
    barof_status_t   status;
    logic        int_clk;

    always_comb begin
        addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
               || (paddr == ADDR_RESULT);
        wr_en   = psel && penable && pwrite && addr_ok;
        force_int_nxt = force_int_r;
        restart_req   = 1'b0;
        if (wr_en && paddr == ADDR_CTRL) begin
            force_int_nxt = pwdata[CTRL_FORCE_BIT];
            restart_req   = pwdata[CTRL_RESTART_BIT];
        end
        status = '{powered: pdn_s, ready: (so_st_r == SO_READY),
                   settled: settled_r, fast: fast_s, int_clk: int_clk};
        prdata_nxt = prdata_r;
        if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL:   prdata_nxt = {30'h0, force_int_r, 1'b0};
                ADDR_STATUS: prdata_nxt = {27'h0, status};
                ADDR_RESULT: prdata_nxt = {12'h0, result_r};
                default:     prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_int_r <= CTRL_FORCE_RESET;
            prdata_r    <= 32'h0;
        end else if (ce) begin
            force_int_r <= force_int_nxt;
            prdata_r    <= prdata_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // =========================================================
    // clock selection and filter
    logic mod_tick;
    logic fast_d_r, src_d_r;
    logic filt_clr;
    barof_sample_t sample;

    barof_clk_select #(
        .DET_CYC   (DET_CYC)
    ) u_clk (
        .clk       (pclk),
        .rst_n     (presetn),
        .ce        (ce),
        .ext_clk_s (ext_s),
        .force_int (force_int_r),
        .int_clk   (int_clk),
        .conv_tick (),
        .mod_tick  (mod_tick)
    );

    // rate or source change invalidates the filter history
    assign filt_clr = !pdn_s || restart_req
                   || (fast_d_r != fast_s) || (src_d_r != int_clk);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_d_r <= 1'b0;
            src_d_r  <= 1'b1;
        end else if (ce) begin
            fast_d_r <= fast_s;
            src_d_r  <= int_clk;
        end
    end

    barof_sinc4 #(
        .DEC_SLOW_P (DEC_SLOW_P),
        .DEC_FAST_P (DEC_FAST_P)
    ) u_filt (
        .clk        (pclk),
        .rst_n      (presetn),
        .ce         (ce),
        .clr        (filt_clr),
        .mod_tick   (mod_tick),
        .mod_bit    (mbit_s),
        .fast       (fast_s),
        .sample     (sample)
    );

    // =========================================================
    // settling count and result holding
    always_comb begin
        settle_cnt_nxt = settle_cnt_r;
        settled_nxt    = settled_r;
        result_nxt     = result_r;
        if (filt_clr) begin
            settle_cnt_nxt = 3'h0;
            settled_nxt    = 1'b0;
        end else if (sample.valid) begin
            result_nxt  = sample.code;
            settled_nxt = (settle_cnt_r == SETTLE_N);
            if (settle_cnt_r != SETTLE_N) begin
                settle_cnt_nxt = settle_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_r <= 3'h0;
            settled_r    <= 1'b0;
            result_r     <= 20'h00000;
        end else if (ce) begin
            settle_cnt_r <= settle_cnt_nxt;
            settled_r    <= settled_nxt;
            result_r     <= result_nxt;
        end
    end

    // =========================================================
    // serial output
    logic                  sclk_d_r;
    logic                  sclk_rise;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [4:0]            bit_cnt_r, bit_cnt_nxt;
    logic                  dout_r, dout_nxt;

    always_comb begin
        sclk_rise   = sclk_s & ~sclk_d_r;
        so_st_nxt   = so_st_r;
        shift_nxt   = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        dout_nxt    = dout_r;
        if (!pdn_s) begin
            so_st_nxt   = SO_IDLE;
            shift_nxt   = '1;
            bit_cnt_nxt = 5'h00;
            dout_nxt    = 1'b1;
        end else if (sample.valid) begin
            shift_nxt   = {sample.code, PAD_ONES};
            bit_cnt_nxt = 5'h00;
            dout_nxt    = 1'b0;
            so_st_nxt   = SO_READY;
        end else if (sclk_rise) begin
            case (so_st_r)
                SO_READY, SO_SHIFT: begin
                    dout_nxt  = shift_r[FRAME_BITS-1];
                    shift_nxt = {shift_r[FRAME_BITS-2:0], 1'b1};
                    so_st_nxt = SO_SHIFT;
                    if (bit_cnt_r != FRAME_CNT) begin
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                    end
                end
                default: begin
                    so_st_nxt = SO_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r  <= 1'b0;
            so_st_r   <= SO_IDLE;
            shift_r   <= '1;
            bit_cnt_r <= 5'h00;
            dout_r    <= 1'b1;
        end else if (ce) begin
            sclk_d_r  <= sclk_s;
            so_st_r   <= so_st_nxt;
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            dout_r    <= dout_nxt;
        end
    end

    assign ready_and_serial_out = dout_r;

    // =========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_load_ready_low: assert property (
        ce && pdn_s && sample.valid
        |=> !ready_and_serial_out && so_st_r == SO_READY)
        else $error("new result did not pull ready line low");
    chk_msb_first: assert property (
        ce && pdn_s && !sample.valid && sclk_rise && so_st_r == SO_READY
        |=> ready_and_serial_out == $past(shift_r[FRAME_BITS-1])
            && bit_cnt_r == 5'h01)
        else $error("first serial edge did not present msb");
    chk_pad_ones: assert property (
        ce && pdn_s && !sample.valid && sclk_rise && bit_cnt_r >= DATA_CNT
        |=> ready_and_serial_out)
        else $error("bits after the twentieth not one");
    chk_atomic_load: assert property (
        ce && pdn_s && sample.valid
        |=> shift_r == {$past(sample.code), PAD_ONES})
        else $error("result not loaded whole into shift register");
    chk_power_off: assert property (
        ce && !pdn_s
        |=> so_st_r == SO_IDLE && settle_cnt_r == 3'h0 && ready_and_serial_out)
        else $error("power off did not reset conversion logic");
    chk_settle_four: assert property (
        settled_r |-> settle_cnt_r == SETTLE_N)
        else $error("settled flag before four conversions");

    cov_read_frame: cover property (
        so_st_r == SO_READY ##[1:1000] (sclk_rise && bit_cnt_r == 5'h17));
    cov_overwrite: cover property (so_st_r == SO_SHIFT && sample.valid);
    cov_settled: cover property ($rose(settled_r));
    cov_source_swap: cover property ($fell(int_clk));

endmodule : barof_top

// File: barof_host_model.sv
// host model that polls the ready line and clocks out each frame
`timescale 1ns/1ps
module barof_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        line,
    output logic             serial_clock,
    output logic             seen,
    output logic      [23:0] word,
    output logic      [31:0] ivl
);
    int cyc = 0;
    int last;
    int h;
    always @(posedge pclk) cyc <= cyc + 1;
    // =========================================
    // frame reader: clock stays low between frames
    initial begin
        serial_clock = 1'b0;
        seen = 1'b0;
        word = 24'h0;
        ivl = 32'h0;
        last = 0;
        forever begin
            @(posedge pclk);
            seen <= 1'b0;
            if (presetn === 1'b1 && line === 1'b0) begin
                ivl <= 32'(cyc - last);
                last = cyc;
                for (int i = 0; i < 24; i++) begin
                    h = 5 + $urandom % 3;
                    serial_clock <= 1'b1;
                    repeat (h) @(posedge pclk);
                    word[23 - i] <= line;
                    serial_clock <= 1'b0;
                    repeat (h) @(posedge pclk);
                end
                seen <= 1'b1;
            end
        end
    end
endmodule : barof_host_model

// File: barof_top_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module barof_top_test
    import barof_pkg::*;
;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic ext, ext_run, rate, pwr, sclk, mbit, line, seen, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, ivl, rd;
    logic [23:0] word;
    logic [55:0] e;
    logic [55:0] q[$];
    int mismatches, total_checks;
    int ec = 0;

    barof_top #(.DEC_SLOW_P(16), .DEC_FAST_P(8), .DET_CYC(40)) barof_top_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_input(ext),
        .rate_select(rate), .power_off_n(pwr), .serial_clock(sclk),
        .modulator_bit(mbit), .ready_and_serial_out(line));
    barof_host_model barof_host_model_inst (
        .pclk(pclk), .presetn(presetn), .line(line), .serial_clock(sclk),
        .seen(seen), .word(word), .ivl(ivl));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // external clock of six pclk periods, grounded when stopped
    always @(posedge pclk) begin
        ec <= (ec == 5) ? 0 : ec + 1;
        ext <= ext_run && ec < 3;
    end
    // =========================================
    // checking helpers
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : cmp
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            cmp(32'h0, 32'h1, "apb timeout");
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task frames(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 60000) begin
            @(posedge pclk);
            k++;
            if (seen === 1'b1) n--;
        end
        if (n > 0) begin
            cmp(32'h0, 32'h1, "frame timeout");
            summarize();
        end
    endtask : frames
    task phase(input logic m, input logic r, input logic [19:0] c,
               input int dec);
        mbit <= m;
        rate <= r;
        frames(5);
        @(posedge pclk);
        q.push_back({c, 4'hF, 32'(64 * dec * 6)});
        frames(1);
        apb(1'b0, ADDR_RESULT, 32'h0);
        cmp(rd, {12'h0, c}, "result register");
    endtask : phase
    // =========================================
    // monitor: oldest note against each frame read while a note is queued
    always @(posedge pclk) begin
        if (seen === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            cmp({8'h0, word}, {8'h0, e[55:32]}, "frame");
            cmp(ivl, e[31:0], "result period");
        end
    end
    // =========================================
    // main sequence
    initial begin
        {ce, pwr, mbit, rate, ext_run} = 5'h1F;
        {psel, penable, pwrite, presetn, err} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        mismatches = 0;
        total_checks = 0;
        void'($urandom(10806));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (100) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[1:0], 32'h2, "clock source and rate");
        apb(1'b1, 8'h0C, 32'hA5);
        cmp({31'h0, err}, 32'h1, "unmapped write");
        apb(1'b0, 8'h0C, 32'h0);
        cmp(rd, 32'h0, "unmapped read");
        ce <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h2);
        ce <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        cmp(rd, 32'h0, "write with clock enable low");
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[0], 32'h1, "forced oscillator");
        apb(1'b0, ADDR_CTRL, 32'h0);
        cmp(rd, 32'h2, "control readback");
        apb(1'b1, ADDR_CTRL, 32'h0);
        phase(1'b1, 1'b1, 20'h00000, 8);
        phase(1'b0, 1'b1, 20'hFFFFF, 8);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h1, "settled after five results");
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h0, "restart clears settled");
        phase(1'b0, 1'b0, 20'hFFFFF, 16);
        pwr <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp({rd[4], 30'h0, line}, 32'h1, "powered off");
        pwr <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[2], 32'h0, "settling restarted");
        ext_run <= 1'b0;
        repeat (200) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        cmp(rd[0], 32'h1, "internal oscillator");
        summarize();
    end
endmodule : barof_top_test
